// >>> qpos_pkg.sv
/*
 Shared constants for the quadrature position decoder: register offsets,
 control field positions, flag bit positions and reset values.
 Assumes a 32-bit classic Wishbone register bus with word-aligned offsets.
*/
// Operation
// - Keep a 32-bit count, plus one clockwise, minus one counterclockwise.
// - Build state from phase B and phase A; direction follows visit order.
// - Every valid transition updates the rotation sense bit.
// - Rotation sense pin always equals the rotation sense bit.
// - Every valid transition sets the movement flag.
// - A step that changes rotation sense sets the sense change flag.
// - Flags stay set until software writes zero; hardware clears only the error flag, when the hold bit is off.
// - Programmable lower bound lets the range roll over away from zero.
// - Capture and compare never touch the count, so work with reload modes.
// - Limit mode reloads: clockwise gets lower bound, counterclockwise gets upper.
// - Without limit mode the count wraps freely across all ones and zero.
// - Clockwise: upper limit flag sets on the same tick the count reloads.
// - Counterclockwise: upper limit flag sets one tick after the reload.
// - Index pulse sets index flag and, in index mode, reloads by direction.
// - Capture edge copies count into capture register and sets capture flag.
// - Compare event whenever count becomes equal to the compare value.
// - Invalid transition sets error flag and pin; hold bit picks sticky.
// - Edge select: A rising, both A edges, all edges; code three reserved.
package qpos_pkg;
	localparam int unsigned POS_W = 32;
	// Register byte offsets
	localparam logic [5:0] OFF_CTRL     = 6'h00;
	localparam logic [5:0] OFF_FLAGS    = 6'h04;
	localparam logic [5:0] OFF_IRQ_EN   = 6'h08;
	localparam logic [5:0] OFF_UPPER    = 6'h0C;
	localparam logic [5:0] OFF_LOWER    = 6'h10;
	localparam logic [5:0] OFF_COMPARE  = 6'h14;
	localparam logic [5:0] OFF_INDEX    = 6'h18;
	localparam logic [5:0] OFF_CAPTURE  = 6'h1C;
	localparam logic [5:0] OFF_STATUS   = 6'h20;
	localparam logic [5:0] OFF_POSITION = 6'h24;
	// Control fields
	localparam int unsigned CTRL_EN      = 0;
	localparam int unsigned CTRL_MODE_LO = 1;
	localparam int unsigned CTRL_LIMIT   = 3;
	localparam int unsigned CTRL_INDEX   = 4;
	localparam int unsigned CTRL_HOLD    = 5;
	localparam int unsigned CTRL_W       = 6;
	// Flag bits, shared by flag and irq enable registers
	localparam int unsigned FL_INDEX   = 0;
	localparam int unsigned FL_ERROR   = 1;
	localparam int unsigned FL_COMPARE = 2;
	localparam int unsigned FL_LIMIT   = 3;
	localparam int unsigned FL_CAPTURE = 4;
	localparam int unsigned FL_SENSE   = 5;
	localparam int unsigned FL_MOVE    = 6;
	localparam int unsigned FL_W       = 7;
	// Edge select codes
	localparam logic [1:0] MODE_A_RISE = 2'h0;
	localparam logic [1:0] MODE_A_BOTH = 2'h1;
	localparam logic [1:0] MODE_ALL    = 2'h2;
	// Reset values
	localparam logic [POS_W-1:0] POS_RST   = 32'h0000_0000;
	localparam logic [POS_W-1:0] UPPER_RST = 32'hFFFF_FFFF;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [FL_W-1:0]   FL_RST   = 7'h00;
	localparam logic [31:0]       DATA_ZERO = 32'h0000_0000;
endpackage : qpos_pkg

// >>> quadrature_position_decoder.sv
/*
 Quadrature position decoder with a classic Wishbone register slave.
 Holds the position count, the reload bounds, the compare target, the
 capture register and the event flags, sticky until written zero, the error flag only with hold set.
 Assumes encoder pins are asynchronous to clk_i and the bus master follows
 classic single-cycle handshakes with an idle cycle between requests.
 The decoder looks at the synchronised encoder state on every rising clk_i edge.
*/
`timescale 1ns/1ps
module quadrature_position_decoder
	import qpos_pkg::*;
(
	input  wire logic                     clk_i,            // System clock
	input  wire logic                     rst_i,            // Sync reset, high
	input  wire logic                     wb_cyc_i,         // Bus cycle
	input  wire logic                     wb_stb_i,         // Bus strobe
	input  wire logic                     wb_we_i,          // Write enable
	input  wire logic [5:0]               wb_adr_i,         // Byte address
	input  wire logic [3:0]               wb_sel_i,         // Byte lanes
	input  wire logic [31:0]              wb_dat_i,         // Write data
	output logic      [31:0]              wb_dat_o,         // Read data
	output logic                          wb_ack_o,         // Acknowledge
	input  wire logic                     phase_a_in_i,     // Encoder phase A
	input  wire logic                     phase_b_in_i,     // Encoder phase B
	input  wire logic                     index_pulse_in_i, // Encoder index
	input  wire logic                     capture_strobe_in_i, // Capture strobe
	output logic                          position_match_out_o, // Count equals target
	output logic                          rotation_sense_out_o, // 1 clockwise
	output logic                          phase_error_out_o     // Invalid transition
);
	import qpos_pkg::*;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : merge_lanes

	// Clockwise successor in the 00, 01, 11, 10 cycle
	function automatic logic [1:0] cw_next(input logic [1:0] s);
		return {s[0], ~s[1]};
	endfunction : cw_next

	// Registered state
	logic [3:0]              sync1_q;
	logic [3:0]              sync2_q;
	logic [3:0]              prev_q;
	logic [CTRL_W-1:0]       ctrl_q;
	logic [FL_W-1:0]         flags_q;
	logic [FL_W-1:0]         flags_d;
	logic [FL_W-1:0]         irq_en_q;
	logic [POS_W-1:0]        upper_q;
	logic [POS_W-1:0]        lower_q;
	logic [POS_W-1:0]        target_q;
	logic [POS_W-1:0]        capture_q;
	logic [POS_W-1:0]        pos_q;
	logic [POS_W-1:0]        pos_d;
	logic                    sense_q;
	logic                    ccw_reload_q;
	logic                    enable_seen_q;
	logic                    ack_q;
	logic [31:0]             rdata_q;

	// Combinational decode
	logic                    req;
	logic                    wr;
	logic [31:0]             wmask;
	logic                    en;
	logic [1:0]              st_now;
	logic [1:0]              st_old;
	logic                    moved;
	logic                    step_valid;
	logic                    step_error;
	logic                    step_cw;
	logic                    count_it;
	logic                    index_edge;
	logic                    capture_edge;
	logic                    limit_cw;
	logic                    limit_ccw_reload;
	logic                    compare_hit;
	logic                    sense_d;
	// Limit flag term and narrow register write images
	logic                    limit_ccw_flag;
	logic [31:0]             ctrl_m;
	logic [31:0]             irq_m;

	// Two-stage synchronisers for the asynchronous encoder pins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end
		else
		begin
			sync1_q <= {capture_strobe_in_i, index_pulse_in_i, phase_b_in_i, phase_a_in_i};
			sync2_q <= sync1_q;
		end
	end

	// History stage for edge detection, fed only by the second flop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			prev_q <= 4'h0;
		else
			prev_q <= sync2_q;
	end

	// Phase state decode
	always_comb
	begin
		en           = ctrl_q[CTRL_EN];
		st_now       = {sync2_q[1], sync2_q[0]};
		st_old       = {prev_q[1], prev_q[0]};
		moved        = (st_now != st_old);
		step_error   = en && moved && (st_now == ~st_old);
		step_valid   = en && moved && !step_error;
		step_cw      = (st_now == cw_next(st_old));
		index_edge   = en && sync2_q[2] && !prev_q[2];
		capture_edge = en && sync2_q[3] && !prev_q[3];
		// Edge select gates which valid steps move the count
		case (ctrl_q[CTRL_MODE_LO +: 2])
			MODE_A_RISE: count_it = step_valid && st_now[0] && !st_old[0];
			MODE_A_BOTH: count_it = step_valid && (st_now[0] != st_old[0]);
			MODE_ALL:    count_it = step_valid;
			default:     count_it = 1'b0;
		endcase
		sense_d = step_valid ? step_cw : sense_q;
	end

	// Next position count
	always_comb
	begin
		pos_d            = pos_q;
		limit_cw         = 1'b0;
		limit_ccw_reload = 1'b0;
		if (index_edge && ctrl_q[CTRL_INDEX])
			pos_d = sense_d ? lower_q : upper_q;
		else if (count_it && step_cw)
		begin
			if (ctrl_q[CTRL_LIMIT] && pos_q == upper_q)
			begin
				pos_d    = lower_q;
				limit_cw = 1'b1;
			end
			else
				pos_d = pos_q + 32'h0000_0001;
		end
		else if (count_it)
		begin
			if (ctrl_q[CTRL_LIMIT] && pos_q == lower_q)
			begin
				pos_d            = upper_q;
				limit_ccw_reload = 1'b1;
			end
			else
				pos_d = pos_q - 32'h0000_0001;
		end
		// Change onto target, or first enabled tick already on target
		compare_hit = en && (pos_d == target_q) &&
			((pos_d != pos_q) || !enable_seen_q);
		// Counterclockwise limit flag waits for the reloaded upper bound
		limit_ccw_flag = ccw_reload_q && en && (pos_q == upper_q);
	end

	// Flag update: hardware set wins over a software write of zero
	always_comb
	begin
		flags_d = flags_q;
		if (wr && wb_adr_i == OFF_FLAGS)
			flags_d = flags_q & (wb_dat_i[FL_W-1:0] | ~wmask[FL_W-1:0]);
		if (!ctrl_q[CTRL_HOLD])
			flags_d[FL_ERROR] = 1'b0;
		if (step_valid)
			flags_d[FL_MOVE] = 1'b1;
		if (step_valid && sense_d != sense_q)
			flags_d[FL_SENSE] = 1'b1;
		if (step_error)
			flags_d[FL_ERROR] = 1'b1;
		if (index_edge)
			flags_d[FL_INDEX] = 1'b1;
		if (capture_edge)
			flags_d[FL_CAPTURE] = 1'b1;
		if (compare_hit)
			flags_d[FL_COMPARE] = 1'b1;
		if (limit_cw || limit_ccw_flag)
			flags_d[FL_LIMIT] = 1'b1;
	end

	// Bus request decode
	always_comb
	begin
		req   = wb_cyc_i && wb_stb_i && !ack_q;
		wr    = req && wb_we_i;
		wmask = merge_lanes(DATA_ZERO, 32'hFFFF_FFFF, wb_sel_i);
		// Lane-merged images of the narrow control and enable registers
		ctrl_m = merge_lanes({26'h0, ctrl_q}, wb_dat_i, wb_sel_i);
		irq_m = merge_lanes({25'h0, irq_en_q}, wb_dat_i, wb_sel_i);
	end

	// Control register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_q <= CTRL_RST;
		else if (wr && wb_adr_i == OFF_CTRL)
			ctrl_q <= ctrl_m[CTRL_W-1:0];
	end

	// Interrupt enable, bounds and compare target
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_en_q <= FL_RST;
			upper_q  <= UPPER_RST;
			lower_q  <= POS_RST;
			target_q <= POS_RST;
		end
		else if (wr)
		begin
			if (wb_adr_i == OFF_IRQ_EN)
				irq_en_q <= irq_m[FL_W-1:0];
			if (wb_adr_i == OFF_UPPER)
				upper_q <= merge_lanes(upper_q, wb_dat_i, wb_sel_i);
			if (wb_adr_i == OFF_LOWER)
				lower_q <= merge_lanes(lower_q, wb_dat_i, wb_sel_i);
			if (wb_adr_i == OFF_COMPARE)
				target_q <= merge_lanes(target_q, wb_dat_i, wb_sel_i);
		end
	end

	// Event flags
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flags_q <= FL_RST;
		else
			flags_q <= flags_d;
	end

	// Position count, held while disabled; capture and compare never write it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pos_q         <= POS_RST;
			ccw_reload_q  <= 1'b0;
			enable_seen_q <= 1'b0;
		end
		else
		begin
			pos_q         <= pos_d;
			ccw_reload_q  <= limit_ccw_reload;
			enable_seen_q <= en;
		end
	end

	// Capture register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			capture_q <= POS_RST;
		else if (capture_edge)
			capture_q <= pos_q;
	end

	// Rotation sense status bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sense_q <= 1'b0;
		else
			sense_q <= sense_d;
	end

	// Rotation sense pin, loaded from the same next value as the status bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rotation_sense_out_o <= 1'b0;
		else
			rotation_sense_out_o <= sense_d;
	end

	// Match pin: enabled and the next count sits on the target
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			position_match_out_o <= 1'b0;
		else
			position_match_out_o <= en && (pos_d == target_q);
	end

	// Error pin mirrors the next error flag, so it pulses without hold
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			phase_error_out_o <= 1'b0;
		else
			phase_error_out_o <= flags_d[FL_ERROR];
	end

	// Bus slave: one wait state, read data registered with ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q   <= 1'b0;
			rdata_q <= DATA_ZERO;
		end
		else
		begin
			ack_q   <= req;
			rdata_q <= DATA_ZERO;
			if (req && !wb_we_i)
			begin
				case (wb_adr_i)
					OFF_CTRL:     rdata_q <= {26'h0, ctrl_q};
					OFF_FLAGS:    rdata_q <= {25'h0, flags_q};
					OFF_IRQ_EN:   rdata_q <= {25'h0, irq_en_q};
					OFF_UPPER:    rdata_q <= upper_q;
					OFF_LOWER:    rdata_q <= lower_q;
					OFF_COMPARE:  rdata_q <= target_q;
					OFF_CAPTURE:  rdata_q <= capture_q;
					OFF_STATUS:   rdata_q <= {31'h0, sense_q};
					OFF_POSITION: rdata_q <= pos_q;
					default:      rdata_q <= DATA_ZERO;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

endmodule : quadrature_position_decoder

// >>> qpos_asserts.sv
/* Port checker for the quadrature position decoder.
 Assumes one clock, synchronous reset and classic Wishbone masters. */
`timescale 1ns/1ps
module qpos_asserts (
	input wire logic	clk_i,	// Clock
	input wire logic	rst_i,	// Reset
	input wire logic	wb_cyc_i,	// Cycle
	input wire logic	wb_stb_i,	// Strobe
	input wire logic	wb_we_i,	// Write
	input wire logic [5:0]	wb_adr_i,	// Address
	input wire logic [3:0]	wb_sel_i,	// Lanes
	input wire logic [31:0]	wb_dat_i,	// Write data
	input wire logic [31:0]	wb_dat_o,	// Read data
	input wire logic	wb_ack_o,	// Ack
	input wire logic	phase_a_in_i,	// Phase A
	input wire logic	phase_b_in_i,	// Phase B
	input wire logic	position_match_out_o,	// Match
	input wire logic	rotation_sense_out_o,	// Sense
	input wire logic	phase_error_out_o	// Error
);
	import qpos_pkg::*;
	logic [1:0] s1_q, s2_q, s3_q;	// Synced state history
	logic en_q, hold_q;	// Control shadow
	logic tr, cw, ccw, bad;
	// Mirror of the pin synchroniser
	always_ff @(posedge clk_i)
	begin
		s1_q <= {phase_b_in_i, phase_a_in_i};
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	// Control bits seen at write acknowledge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			{en_q, hold_q} <= 2'h0;
		else if (wb_ack_o && wb_we_i && wb_adr_i == OFF_CTRL && wb_sel_i[0])
			{en_q, hold_q} <= {wb_dat_i[CTRL_EN], wb_dat_i[CTRL_HOLD]};
	end
	// Step classification
	assign tr = en_q && s2_q != s3_q;
	assign cw = tr && s2_q == {s3_q[0], ~s3_q[1]};
	assign ccw = tr && s2_q == {~s3_q[0], s3_q[1]};
	assign bad = tr && (s2_q ^ s3_q) == 2'h3;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == DATA_ZERO)
		else $error("read data outside ack");
	AST_SENSE_CW: assert property (cw |=> rotation_sense_out_o)
		else $error("sense not set on clockwise step");
	AST_SENSE_CCW: assert property (ccw |=> !rotation_sense_out_o)
		else $error("sense not cleared on counter step");
	AST_SENSE_HOLD: assert property (!cw && !ccw |=> $stable(rotation_sense_out_o))
		else $error("sense moved without a step");
	AST_ERR_SET: assert property (bad |=> phase_error_out_o)
		else $error("error pin not raised");
	AST_ERR_CAUSE: assert property ($rose(phase_error_out_o) |-> $past(bad))
		else $error("error pin raised without cause");
	AST_ERR_TICK: assert property (phase_error_out_o && !hold_q |=> !phase_error_out_o)
		else $error("error pin held without hold bit");
	AST_MATCH_OFF: assert property (!en_q && !$past(en_q) |-> !position_match_out_o)
		else $error("match pin while disabled");
	COV_CW: cover property (cw ##1 rotation_sense_out_o);
	COV_BAD: cover property (bad);
	COV_MATCH: cover property ($rose(position_match_out_o));
endmodule : qpos_asserts
bind quadrature_position_decoder qpos_asserts qpos_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.phase_a_in_i(phase_a_in_i), .phase_b_in_i(phase_b_in_i),
	.position_match_out_o(position_match_out_o), .rotation_sense_out_o(rotation_sense_out_o),
	.phase_error_out_o(phase_error_out_o));

// >>> qpos_encoder.sv
/* Rotary encoder model driving phase, index and capture pins.
 Assumes the decoder needs each level held three clocks. */
`timescale 1ns/1ps
module qpos_encoder (
	input wire logic	clk_i,	// Clock
	output logic	a_o,	// Phase A
	output logic	b_o,	// Phase B
	output logic	idx_o,	// Index
	output logic	cap_o	// Capture
);
	logic [1:0] st_q = 2'h0;	// State {B,A}
	// Pins follow the state
	assign {b_o, a_o} = st_q;
	// Quarter step: 1 clockwise, 0 counter, 2 invalid
	task automatic step(input int k);
		@(posedge clk_i);
		if (k == 2)
			st_q <= ~st_q;
		else if (k == 1)
			st_q <= {st_q[0], ~st_q[1]};
		else
			st_q <= {~st_q[0], st_q[1]};
		repeat (6) @(posedge clk_i);
	endtask : step
	// Index or capture pulse
	task automatic pulse(input logic ix);
		@(posedge clk_i);
		idx_o <= ix;
		cap_o <= !ix;
		repeat (4) @(posedge clk_i);
		idx_o <= 1'b0;
		cap_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask : pulse
	// Idle pins
	initial
	begin
		idx_o = 1'b0;
		cap_o = 1'b0;
	end
endmodule : qpos_encoder

// >>> quadrature_position_decoder_tb.sv
/* Self-checking bench for the quadrature position decoder.
 Assumes the encoder model and the bound checker compile alongside. */
`timescale 1ns/1ps
module quadrature_position_decoder_tb;
	import qpos_pkg::*;
	localparam logic [31:0] FULL = 32'hFFFF_FFFF;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [3:0] wb_sel_i = 4'hF, sel_m = 4'hF;
	logic [31:0] rnd_m = 32'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pos_m = 32'h0, up_m = UPPER_RST, lo_m = POS_RST;
	logic wb_ack_o, match_o, sense_o, err_o, a, b, idx, cap, sense_m = 1'b0, lim = 1'b0;
	int failures = 0, cmp_count = 0, cycles = 0, seed = 32'hA28C;
	quadrature_position_decoder quadrature_position_decoder_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.phase_a_in_i(a), .phase_b_in_i(b), .index_pulse_in_i(idx), .capture_strobe_in_i(cap),
		.position_match_out_o(match_o), .rotation_sense_out_o(sense_o), .phase_error_out_o(err_o));
	qpos_encoder qpos_encoder_inst (.clk_i(clk_i), .a_o(a), .b_o(b), .idx_o(idx), .cap_o(cap));
	// Clock and hang guard
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Classic single cycle, held until ack
	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
		wb_adr_i <= ad;
		wb_sel_i <= sel_m;
		wb_dat_i <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask : bus
	task automatic wr(input logic [5:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, q);
	endtask : wr
	task automatic rdc(input logic [5:0] ad, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, ad, DATA_ZERO, q);
		chk(q & m, e);
	endtask : rdc
	function automatic logic [31:0] fb(input int n);
		return 32'h1 << n;
	endfunction : fb
	// Disable, configure, clear flags, enable
	task automatic cfg(input logic [31:0] c, input logic [31:0] irq);
		wr(OFF_CTRL, DATA_ZERO);
		wr(OFF_CTRL, c);
		wr(OFF_UPPER, up_m);
		wr(OFF_LOWER, lo_m);
		wr(OFF_COMPARE, ~pos_m);
		wr(OFF_FLAGS, DATA_ZERO);
		wr(OFF_IRQ_EN, irq);
		wr(OFF_CTRL, c | 32'h1);
		lim = c[CTRL_LIMIT];
	endtask : cfg
	// Step the encoder and the model together
	task automatic walk(input int d);
		qpos_encoder_inst.step(d);
		if (d == 1)
			pos_m = (lim && pos_m == up_m) ? lo_m : pos_m + 32'h1;
		else
			pos_m = (lim && pos_m == lo_m) ? up_m : pos_m - 32'h1;
		sense_m = d[0];
		rdc(OFF_POSITION, FULL, pos_m);
		chk({31'h0, sense_o}, {31'h0, sense_m});
	endtask : walk
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(OFF_CTRL, FULL, CTRL_RST);
		rdc(OFF_UPPER, FULL, UPPER_RST);
		rdc(6'h3C, FULL, DATA_ZERO);
		wr(OFF_POSITION, FULL);
		rdc(OFF_POSITION, FULL, POS_RST);
		// Byte lanes: only lane 1 of a random word lands
		rnd_m = $random(seed);
		sel_m = 4'h2;
		wr(OFF_LOWER, rnd_m);
		sel_m = 4'hF;
		rdc(OFF_LOWER, FULL, rnd_m & 32'h0000_FF00);
		// Count already on the reset target when first enabled
		wr(OFF_CTRL, 32'h5);
		rdc(OFF_FLAGS, fb(FL_COMPARE), fb(FL_COMPARE));
		chk({31'h0, match_o}, 32'h1);
		$display("reset test done");
		cfg(32'h4, fb(FL_MOVE));
		walk(0);
		walk(1);
		repeat (10) walk($random(seed) & 1);
		rdc(OFF_FLAGS, 32'h60, fb(FL_MOVE) | fb(FL_SENSE));
		wr(OFF_FLAGS, DATA_ZERO);
		rdc(OFF_FLAGS, FULL, FL_RST);
		walk(sense_m);
		rdc(OFF_FLAGS, 32'h60, fb(FL_MOVE));
		$display("free count test done");
		lo_m = pos_m - 32'h1;
		up_m = pos_m + 32'h2;
		cfg(32'hC, fb(FL_LIMIT));
		walk(1);
		walk(1);
		wr(OFF_FLAGS, DATA_ZERO);
		walk(1);
		rdc(OFF_FLAGS, fb(FL_LIMIT), fb(FL_LIMIT));
		wr(OFF_FLAGS, DATA_ZERO);
		walk(0);
		rdc(OFF_FLAGS, fb(FL_LIMIT), fb(FL_LIMIT));
		// Target one step below the count: cfg loads the inverse of the model
		pos_m = ~(pos_m - 32'h1);
		cfg(32'hC, fb(FL_COMPARE));
		pos_m = ~pos_m + 32'h1;
		walk(0);
		rdc(OFF_FLAGS, fb(FL_COMPARE), fb(FL_COMPARE));
		chk({31'h0, match_o}, 32'h1);
		qpos_encoder_inst.pulse(1'b0);
		rdc(OFF_CAPTURE, FULL, pos_m);
		rdc(OFF_POSITION, FULL, pos_m);
		rdc(OFF_FLAGS, fb(FL_CAPTURE), fb(FL_CAPTURE));
		$display("limit compare capture test done");
		cfg(32'h14, fb(FL_INDEX));
		repeat (2)
		begin
			qpos_encoder_inst.pulse(1'b1);
			pos_m = sense_m ? lo_m : up_m;
			rdc(OFF_POSITION, FULL, pos_m);
			rdc(OFF_FLAGS, fb(FL_INDEX), fb(FL_INDEX));
			walk(1);
		end
		cfg(32'h24, 32'h0);
		qpos_encoder_inst.step(2);
		rdc(OFF_FLAGS, fb(FL_ERROR), fb(FL_ERROR));
		chk({31'h0, err_o}, 32'h1);
		rdc(OFF_POSITION, FULL, pos_m);
		wr(OFF_FLAGS, DATA_ZERO);
		cfg(32'h4, 32'h0);
		qpos_encoder_inst.step(2);
		rdc(OFF_FLAGS, fb(FL_ERROR), 32'h0);
		wr(OFF_CTRL, 32'h4);
		wr(OFF_FLAGS, DATA_ZERO);
		qpos_encoder_inst.step(1);
		rdc(OFF_POSITION, FULL, pos_m);
		rdc(OFF_FLAGS, FULL, FL_RST);
		$display("index error disable test done");
		for (int m = 0; m < 4; m++)
		begin
			cfg(m << 1, 32'h0);
			repeat (4) qpos_encoder_inst.step(1);
			pos_m = pos_m + ((m == 3) ? 32'h0 : (32'h1 << m));
			rdc(OFF_POSITION, FULL, pos_m);
		end
		$display("edge select test done");
		end_sim();
	end
endmodule : quadrature_position_decoder_tb
